/* File: src/autoneg_ability_registers.sv */
// Auto-negotiation advertisement, partner ability and expansion registers
//
// How it works
// - Pause field bits 11:10 encode none, sym, asym or both; resets to zero.
// - With both pause bits set, resolve to at most one mode on completion.
// - Advertised 100FD, 10FD and 10HD bits reset from the mode straps.
// - Advertised 100HD bit resets to one.
// - Advertised 10FD bit set means full duplex ability, clear means none.
// - Selector field reads IEEE 802.3; writable in advertise, fixed in partner.
// - Partner next-page bit is read-only and always zero.
// - Partner acknowledge is set once a code word arrives, zero before.
// - Partner remote-fault reports the partner fault bit, resets zero.
// - Partner pause bit reports partner pause support.
// - Partner T4 bit is read-only, resets zero.
// - Partner speed/duplex bits mirror the received code word, reset zero.
// - Expansion flags parallel detection fault, resets zero.
// - Expansion shows partner next page ability.
// - Local next-page-able expansion bit reads zero.
// - Page-received bit latches high on a new page, resets zero.
// - Expansion shows partner auto-negotiation ability.
// - Restart request input high restarts negotiation; the restart bit follows it one cycle later and clears one cycle after it drops.
`timescale 1ns/1ps
`include "autoneg_map.svh"

module autoneg_ability_registers (
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   soft_rst_i,
  input  wire logic [2:0]             mode_strap_i,
  input  wire autoneg_pkg::mgmt_req_t mgmt_i,
  output logic      [15:0]            rdata_o,
  output logic                        rvalid_o,
  input  wire logic                   restart_req_i,
  output logic                        restart_o,
  output logic                        restart_pending_o,
  input  wire autoneg_pkg::link_evt_t link_i,
  output autoneg_pkg::pause_res_t     pause_res_o
);
  import autoneg_pkg::*;

  // ----------------------------------------------------------------
  // Strap synchroniser
  // ----------------------------------------------------------------
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;

  always_ff @(posedge clk_i) begin
    strap_meta <= mode_strap_i;
    strap_sync <= strap_meta;
  end

  function automatic logic [2:0] strap_abil(input logic [2:0] m);
    // Returns {100FD, 10FD, 10HD} advertised for a mode strap value
    case (m)
      3'h0: strap_abil = 3'b000;
      3'h1: strap_abil = 3'b010;
      3'h2: strap_abil = 3'b000;
      3'h3: strap_abil = 3'b100;
      default: strap_abil = 3'b111;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic        adv_rfault;
  logic [1:0]  adv_pause;
  logic        adv_100fd;
  logic        adv_100hd;
  logic        adv_10fd;
  logic        adv_10hd;
  logic [4:0]  adv_sel;
  logic [15:0] lpa;
  logic        lpa_ack;
  logic        pdf_latch;
  logic        page_latch;
  logic        restart;
  logic        restart_q;
  logic        strap_load;
  pause_res_t  pause_res;

  logic        next_adv_rfault;
  logic [1:0]  next_adv_pause;
  logic        next_adv_100fd;
  logic        next_adv_100hd;
  logic        next_adv_10fd;
  logic        next_adv_10hd;
  logic [4:0]  next_adv_sel;
  logic [15:0] next_lpa;
  logic        next_lpa_ack;
  logic        next_pdf_latch;
  logic        next_page_latch;
  logic        next_restart;
  logic        next_strap_load;
  pause_res_t  next_pause_res;
  logic [15:0] next_rdata;
  logic        next_rvalid;

  logic        any_rst;
  logic        wr_adv;
  logic        rd_adv;
  logic        rd_exp;
  logic        rd_lpa;
  logic [15:0] adv_word;
  logic [15:0] lpa_word;
  logic [15:0] exp_word;

  function automatic logic reg_hit(input mgmt_req_t m, input logic wr, input logic [4:0] idx);
    // True when a request targets one register in one direction
    reg_hit = m.req & (m.wr == wr) & (m.idx == idx);
  endfunction

  assign any_rst = sys_rst_i | soft_rst_i;
  assign wr_adv  = reg_hit(mgmt_i, 1'b1, `AN_IDX_ADVERTISE);
  assign rd_adv  = reg_hit(mgmt_i, 1'b0, `AN_IDX_ADVERTISE);
  assign rd_lpa  = reg_hit(mgmt_i, 1'b0, `AN_IDX_PARTNER);
  assign rd_exp  = reg_hit(mgmt_i, 1'b0, `AN_IDX_EXPANSION);

  // ----------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------
  always_comb begin
    adv_word = 16'h0000;
    adv_word[`AN_BIT_RFAULT] = adv_rfault;
    adv_word[`AN_BIT_PAUSE_HI:`AN_BIT_PAUSE_LO] = adv_pause;
    adv_word[`AN_BIT_100FD] = adv_100fd;
    adv_word[`AN_BIT_100HD] = adv_100hd;
    adv_word[`AN_BIT_10FD] = adv_10fd;
    adv_word[`AN_BIT_10HD] = adv_10hd;
    adv_word[4:0] = adv_sel;
    adv_word = adv_word & ~`AN_ADV_RESERVED_MASK;

    lpa_word = lpa & ~`AN_LPA_RESERVED_MASK;
    lpa_word[`AN_BIT_LP_NP] = 1'b0;
    lpa_word[`AN_BIT_LP_ACK] = lpa_ack;
    lpa_word[`AN_BIT_LP_T4] = 1'b0;
    lpa_word[4:0] = `AN_SELECTOR_8023;

    exp_word = 16'h0000;
    exp_word[`AN_EXP_PDF] = pdf_latch;
    exp_word[`AN_EXP_LP_NP] = lpa[`AN_BIT_LP_NP];
    exp_word[`AN_EXP_LOCAL_NP] = 1'b0;
    exp_word[`AN_EXP_PAGE_RX] = page_latch;
    exp_word[`AN_EXP_LP_AN] = link_i.partner_an_able;
  end

  // ----------------------------------------------------------------
  // Advertisement register
  // ----------------------------------------------------------------
  always_comb begin
    next_adv_rfault = adv_rfault;
    next_adv_pause  = adv_pause;
    next_adv_100fd  = adv_100fd;
    next_adv_100hd  = adv_100hd;
    next_adv_10fd   = adv_10fd;
    next_adv_10hd   = adv_10hd;
    next_adv_sel    = adv_sel;
    next_strap_load = 1'b0;
    if (strap_load) begin
      {next_adv_100fd, next_adv_10fd, next_adv_10hd} = strap_abil(strap_sync);
    end
    if (wr_adv) begin
      // Read-only and reserved bits keep their value
      next_adv_rfault = mgmt_i.wdata[`AN_BIT_RFAULT];
      next_adv_pause  = mgmt_i.wdata[`AN_BIT_PAUSE_HI:`AN_BIT_PAUSE_LO];
      next_adv_100fd  = mgmt_i.wdata[`AN_BIT_100FD];
      next_adv_100hd  = mgmt_i.wdata[`AN_BIT_100HD];
      next_adv_10fd   = mgmt_i.wdata[`AN_BIT_10FD];
      next_adv_10hd   = mgmt_i.wdata[`AN_BIT_10HD];
      next_adv_sel    = mgmt_i.wdata[4:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      adv_rfault <= 1'b0;
      adv_pause  <= 2'h0;
      adv_100fd  <= 1'b0;
      adv_100hd  <= 1'b1;
      adv_10fd   <= 1'b0;
      adv_10hd   <= 1'b0;
      adv_sel    <= `AN_SELECTOR_8023;
      strap_load <= 1'b1;
    end else begin
      adv_rfault <= next_adv_rfault;
      adv_pause  <= next_adv_pause;
      adv_100fd  <= next_adv_100fd;
      adv_100hd  <= next_adv_100hd;
      adv_10fd   <= next_adv_10fd;
      adv_10hd   <= next_adv_10hd;
      adv_sel    <= next_adv_sel;
      strap_load <= next_strap_load;
    end
  end

  // ----------------------------------------------------------------
  // Partner ability capture
  // ----------------------------------------------------------------
  always_comb begin
    next_lpa     = lpa;
    next_lpa_ack = lpa_ack;
    if (link_i.page_valid) begin
      next_lpa     = link_i.code_word;
      next_lpa_ack = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      lpa     <= 16'h0000;
      lpa_ack <= 1'b0;
    end else begin
      lpa     <= next_lpa;
      lpa_ack <= next_lpa_ack;
    end
  end

  // ----------------------------------------------------------------
  // Expansion latches
  // ----------------------------------------------------------------
  always_comb begin
    next_pdf_latch  = pdf_latch;
    next_page_latch = page_latch;
    // Read clears, but a pending event wins
    if (rd_exp) begin
      next_page_latch = 1'b0;
      next_pdf_latch  = 1'b0;
    end
    if (link_i.page_valid) begin
      next_page_latch = 1'b1;
    end
    if (link_i.parallel_fault) begin
      next_pdf_latch = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      pdf_latch  <= 1'b0;
      page_latch <= 1'b0;
    end else begin
      pdf_latch  <= next_pdf_latch;
      page_latch <= next_page_latch;
    end
  end

  // ----------------------------------------------------------------
  // Restart request
  // ----------------------------------------------------------------
  always_comb begin
    next_restart = restart_req_i;
  end

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      restart   <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      restart   <= next_restart;
      restart_q <= restart;
    end
  end

  // ----------------------------------------------------------------
  // Pause resolution
  // ----------------------------------------------------------------
  always_comb begin
    next_pause_res = pause_res;
    if (restart) begin
      next_pause_res = PAUSE_OFF;
    end else if (link_i.an_complete) begin
      // Both local bits set: pick sym if partner pauses, else asym
      if (adv_pause == `AN_PAUSE_NONE) begin
        next_pause_res = PAUSE_OFF;
      end else if (adv_pause == `AN_PAUSE_SYM) begin
        next_pause_res = lpa[`AN_BIT_PAUSE_LO] ? PAUSE_SYM : PAUSE_OFF;
      end else if (adv_pause == `AN_PAUSE_ASYM) begin
        next_pause_res = lpa[`AN_BIT_PAUSE_LO] ? PAUSE_ASYM : PAUSE_OFF;
      end else begin
        next_pause_res = lpa[`AN_BIT_PAUSE_LO] ? PAUSE_SYM : PAUSE_ASYM;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      pause_res <= PAUSE_OFF;
    end else begin
      pause_res <= next_pause_res;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    next_rvalid = mgmt_i.req & ~mgmt_i.wr;
    next_rdata  = rdata_o;
    if (rd_adv) begin
      next_rdata = adv_word;
    end else if (rd_lpa) begin
      next_rdata = lpa_word;
    end else if (rd_exp) begin
      next_rdata = exp_word;
    end else if (next_rvalid) begin
      // Unmapped index reads zero
      next_rdata = 16'h0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      rdata_o  <= 16'h0000;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o  <= next_rdata;
      rvalid_o <= next_rvalid;
    end
  end

  assign restart_o         = restart;
  assign restart_pending_o = restart | restart_q;
  assign pause_res_o       = pause_res;

endmodule // autoneg_ability_registers

/* File: src/autoneg_map.svh */
// Register indices, field positions, reset values and masks for the autoneg registers
`ifndef AUTONEG_MAP_SVH
`define AUTONEG_MAP_SVH

`define AN_IDX_ADVERTISE     5'h04
`define AN_IDX_PARTNER       5'h05
`define AN_IDX_EXPANSION     5'h06

`define AN_SELECTOR_8023     5'h01
`define AN_ADV_RO_MASK       16'hc200
`define AN_ADV_RESERVED_MASK 16'hd200
`define AN_LPA_RESERVED_MASK 16'h1800
`define AN_EXP_RESERVED_MASK 16'hffe0

`define AN_BIT_RFAULT        13
`define AN_BIT_PAUSE_HI      11
`define AN_BIT_PAUSE_LO      10
`define AN_BIT_100FD         8
`define AN_BIT_100HD         7
`define AN_BIT_10FD          6
`define AN_BIT_10HD          5
`define AN_BIT_LP_NP         15
`define AN_BIT_LP_ACK        14
`define AN_BIT_LP_T4         9

`define AN_EXP_PDF           4
`define AN_EXP_LP_NP         3
`define AN_EXP_LOCAL_NP      2
`define AN_EXP_PAGE_RX       1
`define AN_EXP_LP_AN         0

`define AN_PAUSE_NONE        2'h0
`define AN_PAUSE_SYM         2'h1
`define AN_PAUSE_ASYM        2'h2

`endif

/* File: src/autoneg_pkg.sv */
// Types shared by the autoneg register bank
package autoneg_pkg;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [4:0]  idx;
    logic [15:0] wdata;
  } mgmt_req_t;

  typedef struct packed {
    logic        page_valid;
    logic [15:0] code_word;
    logic        partner_an_able;
    logic        parallel_fault;
    logic        an_complete;
  } link_evt_t;

  typedef enum logic [1:0] {
    PAUSE_OFF,
    PAUSE_SYM,
    PAUSE_ASYM
  } pause_res_t;

endpackage

/* File: testbench/autoneg_ability_registers_asserts.sv */
// Port-level checks for the autoneg register bank
`timescale 1ns/1ps
`include "autoneg_map.svh"

module autoneg_ability_registers_asserts (
  input wire logic                   clk_i,
  input wire logic                   sys_rst_i,
  input wire logic                   soft_rst_i,
  input wire autoneg_pkg::mgmt_req_t mgmt_i,
  input wire logic [15:0]            rdata_o,
  input wire logic                   restart_req_i,
  input wire logic                   restart_o,
  input wire logic                   restart_pending_o,
  input wire autoneg_pkg::link_evt_t link_i
);
  import autoneg_pkg::*;
  logic rd5;
  logic rd6;
  logic quiet;
  assign rd5 = mgmt_i.req && !mgmt_i.wr && mgmt_i.idx == `AN_IDX_PARTNER;
  assign rd6 = mgmt_i.req && !mgmt_i.wr && mgmt_i.idx == `AN_IDX_EXPANSION;
  assign quiet = !link_i.page_valid && !link_i.parallel_fault;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i || soft_rst_i);
  a_restart_pulse: assert property (restart_req_i |=> restart_o)
    else $error("restart pulse missing");
  a_pending_hold: assert property (restart_o |->
    restart_pending_o ##1 restart_pending_o)
    else $error("restart bit cleared too early");
  a_pending_end: assert property (restart_o && !restart_req_i ##1 !restart_req_i
    |=> !restart_pending_o)
    else $error("restart bit did not self-clear");
  a_exp_reserved: assert property (rd6 |=> rdata_o[15:5] == 11'h000)
    else $error("expansion reserved bits not zero");
  a_exp_local_np: assert property (rd6 |=> !rdata_o[`AN_EXP_LOCAL_NP])
    else $error("local next page bit set");
  a_lpa_fixed: assert property (rd5 |=> rdata_o[15] == 1'b0
    && rdata_o[9] == 1'b0 && rdata_o[4:0] == `AN_SELECTOR_8023)
    else $error("partner fixed bits wrong");
  a_page_latch: assert property (link_i.page_valid ##1 rd6
    |=> rdata_o[`AN_EXP_PAGE_RX])
    else $error("page received not latched");
  a_pdf_latch: assert property (link_i.parallel_fault ##1 rd6
    |=> rdata_o[`AN_EXP_PDF])
    else $error("parallel fault not latched");
  a_latch_clear: assert property (rd6 && quiet ##1 quiet ##1 (rd6 && quiet)
    |=> rdata_o[4] == 1'b0 && rdata_o[1] == 1'b0)
    else $error("latched bits not cleared by read");
endmodule // autoneg_ability_registers_asserts

bind autoneg_ability_registers autoneg_ability_registers_asserts chk_u (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst_i), .mgmt_i(mgmt_i),
  .rdata_o(rdata_o), .restart_req_i(restart_req_i), .restart_o(restart_o),
  .restart_pending_o(restart_pending_o), .link_i(link_i));

/* File: testbench/mgmt_host_model.sv */
// Station management controller model issuing register accesses
`timescale 1ns/1ps

module mgmt_host_model (
  input  wire logic              clk_i,
  input  wire logic [15:0]       rdata_i,
  input  wire logic              rvalid_i,
  output autoneg_pkg::mgmt_req_t mgmt_o,
  output logic                   restart_req_o
);
  import autoneg_pkg::*;
  initial begin
    mgmt_o = '0;
    restart_req_o = 1'b0;
  end
  // Request for one cycle, then released fields are scrambled and one cycle idles
  task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] wdata,
                        output logic [15:0] rdata);
    mgmt_o = '{req: 1'b1, wr: wr, idx: idx, wdata: wdata};
    @(negedge clk_i);
    rdata = (wr || rvalid_i === 1'b1) ? rdata_i : 16'hxxxx;
    mgmt_o = '{req: 1'b0, wr: ~wr, idx: ~idx, wdata: ~wdata};
    @(negedge clk_i);
  endtask
  task automatic restart();
    restart_req_o = 1'b1;
    @(negedge clk_i);
    restart_req_o = 1'b0;
  endtask
endmodule // mgmt_host_model

/* File: testbench/testbench.sv */
// Self-checking bench for the autoneg register bank
`timescale 1ns/1ps
`include "autoneg_map.svh"
`define CHK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("FAIL %s expected %h seen %h", name, exp, got); end end

module testbench;
  import autoneg_pkg::*;
  logic        clk_i;
  logic        sys_rst_i;
  logic        soft_rst_i;
  logic [2:0]  mode_strap_i;
  mgmt_req_t   mgmt_i;
  logic [15:0] rdata_o;
  logic        rvalid_o;
  logic        restart_req_i;
  logic        restart_o;
  logic        restart_pending_o;
  link_evt_t   link_i;
  pause_res_t  pause_res_o;
  logic [15:0] d;
  logic [2:0]  straps [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  logic [15:0] advs [4] = '{16'h0081, 16'h00c1, 16'h0181, 16'h01e1};
  int          n_errors = 0;
  int          checks_done = 0;
  int          cycles = 0;

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  autoneg_ability_registers dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .soft_rst_i(soft_rst_i), .mode_strap_i(mode_strap_i), .mgmt_i(mgmt_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .restart_req_i(restart_req_i),
    .restart_o(restart_o), .restart_pending_o(restart_pending_o), .link_i(link_i),
    .pause_res_o(pause_res_o));
  mgmt_host_model host_u (.clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
    .mgmt_o(mgmt_i), .restart_req_o(restart_req_i));

  task automatic rd(input logic [4:0] idx, input logic [15:0] exp, input string name);
    host_u.access(1'b0, idx, 16'h0000, d);
    `CHK(name, exp, d)
  endtask
  task automatic wr(input logic [4:0] idx, input logic [15:0] v);
    host_u.access(1'b1, idx, v, d);
  endtask
  task automatic evt(input logic pg, input logic pdf, input logic cpl, input logic [15:0] cw);
    link_i.code_word = cw;
    link_i.page_valid = pg;
    link_i.parallel_fault = pdf;
    link_i.an_complete = cpl;
    @(negedge clk_i);
    link_i.page_valid = 1'b0;
    link_i.parallel_fault = 1'b0;
    link_i.an_complete = 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    sys_rst_i = 1'b1;
    soft_rst_i = 1'b0;
    mode_strap_i = 3'h0;
    link_i = '0;
    for (int i = 0; i < 4; i++) begin
      sys_rst_i = 1'b1;
      mode_strap_i = straps[i];
      repeat (10) @(negedge clk_i);
      sys_rst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      rd(`AN_IDX_ADVERTISE, advs[i], "adv reset");
    end
    rd(`AN_IDX_PARTNER, 16'h0001, "lpa reset");
    rd(`AN_IDX_EXPANSION, 16'h0000, "exp reset");
    rd(5'h1f, 16'h0000, "unmapped");
    wr(`AN_IDX_ADVERTISE, 16'hffff);
    rd(`AN_IDX_ADVERTISE, 16'h2dff, "adv ones");
    wr(`AN_IDX_ADVERTISE, 16'h0000);
    rd(`AN_IDX_ADVERTISE, 16'h0000, "adv zeros");
    wr(`AN_IDX_PARTNER, 16'hffff);
    wr(`AN_IDX_EXPANSION, 16'hffff);
    rd(`AN_IDX_PARTNER, 16'h0001, "lpa write");
    rd(`AN_IDX_EXPANSION, 16'h0000, "exp write");
    wr(`AN_IDX_ADVERTISE, 16'h0c01);
    link_i.partner_an_able = 1'b1;
    evt(1'b1, 1'b1, 1'b0, 16'hffff);
    rd(`AN_IDX_EXPANSION, 16'h001b, "exp page");
    rd(`AN_IDX_EXPANSION, 16'h0009, "exp reread");
    rd(`AN_IDX_PARTNER, 16'h65e1, "lpa page");
    evt(1'b0, 1'b0, 1'b1, 16'hffff);
    @(negedge clk_i);
    `CHK("pause sym", PAUSE_SYM, pause_res_o)
    host_u.restart();
    `CHK("restart", 1'b1, restart_o)
    @(negedge clk_i);
    `CHK("pending", 1'b1, restart_pending_o)
    @(negedge clk_i);
    `CHK("pending end", 1'b0, restart_pending_o)
    `CHK("pause off", PAUSE_OFF, pause_res_o)
    evt(1'b1, 1'b0, 1'b0, 16'h0001);
    evt(1'b0, 1'b0, 1'b1, 16'h0001);
    @(negedge clk_i);
    `CHK("pause asym", PAUSE_ASYM, pause_res_o)
    wr(`AN_IDX_ADVERTISE, 16'h0401);
    evt(1'b0, 1'b0, 1'b1, 16'h0000);
    @(negedge clk_i);
    `CHK("pause sym none", PAUSE_OFF, pause_res_o)
    wr(`AN_IDX_ADVERTISE, 16'h0801);
    evt(1'b1, 1'b0, 1'b0, 16'h0401);
    evt(1'b0, 1'b0, 1'b1, 16'h0401);
    @(negedge clk_i);
    `CHK("pause asym only", PAUSE_ASYM, pause_res_o)
    wr(`AN_IDX_ADVERTISE, 16'h0401);
    evt(1'b0, 1'b0, 1'b1, 16'h0401);
    @(negedge clk_i);
    `CHK("pause sym only", PAUSE_SYM, pause_res_o)
    wr(`AN_IDX_ADVERTISE, 16'h0001);
    evt(1'b0, 1'b0, 1'b1, 16'h0401);
    @(negedge clk_i);
    `CHK("pause none", PAUSE_OFF, pause_res_o)
    soft_rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    soft_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    rd(`AN_IDX_ADVERTISE, 16'h01e1, "adv soft");
    rd(`AN_IDX_PARTNER, 16'h0001, "lpa soft");
    rd(`AN_IDX_EXPANSION, 16'h0001, "exp soft");
    test_done();
  end
endmodule // testbench
